// File: coproc_pkg.sv
// Constants shared by the coprocessor transfer port.
// Assumes a 32-bit instruction word and a 26-bit address space.
package coproc_pkg;

   // ==========================================
   // Instruction fields
   localparam int COND_MSB   = 31;
   localparam int COND_LSB   = 28;
   localparam int BIT_PRE    = 24;
   localparam int BIT_UP     = 23;
   localparam int BIT_LONG   = 22;
   localparam int BIT_WB     = 21;
   localparam int BIT_LOAD   = 20;
   localparam int RN_MSB     = 19;
   localparam int RN_LSB     = 16;
   localparam int RD_MSB     = 15;
   localparam int RD_LSB     = 12;
   localparam int CPN_MSB    = 11;
   localparam int CPN_LSB    = 8;
   localparam int OFF_MSB    = 7;
   localparam int BIT_REGX   = 4;
   localparam int CLASS_MSB  = 27;
   localparam int MEM_LSB    = 25;
   localparam int REGX_LSB   = 24;

   localparam logic [2:0] CLASS_MEM  = 3'h6;
   localparam logic [3:0] CLASS_REGX = 4'he;
   localparam logic [3:0] REG_PC     = 4'hf;

   // ==========================================
   // Addressing
   localparam int          ADDR_BITS   = 26;
   localparam int          OFF_SHIFT   = 2;
   localparam logic [31:0] PC_AHEAD    = 32'h0000_0008;
   localparam logic [31:0] PC_ADDR_MSK = 32'h03ff_fffc;
   localparam logic [25:0] WORD_STEP   = 26'h000_0004;
   localparam int          FLAG_MSB    = 31;
   localparam int          FLAG_LSB    = 28;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_MEM,
      ST_MOVE_IN,
      ST_MOVE_OUT
   } state_t;

endpackage

// File: cond_check.sv
// Condition field evaluator against the four arithmetic flags.
// Combinational; flags ordered negative, zero, carry, overflow.
module cond_check (
   input  wire logic [3:0] cond,   // Condition field
   input  wire logic [3:0] flags,  // N Z C V
   output logic            pass    // Condition holds
);
   logic n, z, c, v;

   always_comb begin
      {n, z, c, v} = flags;
      case (cond)
         4'h0: pass = z;
         4'h1: pass = !z;
         4'h2: pass = c;
         4'h3: pass = !c;
         4'h4: pass = n;
         4'h5: pass = !n;
         4'h6: pass = v;
         4'h7: pass = !v;
         4'h8: pass = c && !z;
         4'h9: pass = !c || z;
         4'ha: pass = (n == v);
         4'hb: pass = (n != v);
         4'hc: pass = !z && (n == v);
         4'hd: pass = z || (n != v);
         4'he: pass = 1'b1;
         default: pass = 1'b0;
      endcase
   end
endmodule

// File: coproc_transfer_port.sv
// Processor-side port for coprocessor memory and register transfers.
// Assumes the register file and memory sit on clk; coprocessor and
// memory manager strobes arrive from pins and are synchronised here.
//
// Contract
// - First word at base, or base plus or minus offset if pre-indexed; then plus four each
// - Program counter base drops status flag bits
// - Program counter base reads eight bytes ahead
// - Privileged post-indexed writeback drives translation low
// - Only first address checked; later addresses wrap
// - Check applies to the address actually issued
// - Abort takes trap yet still writes base back
// - Bit 22 selects long or short transfer
// - Post-indexed uses base, always writes back
// - Pre-indexed uses offset, writes back if asked
// - Offset reaches 1020 bytes, word multiples only
// - Register transfer runs only if condition true
// - Opcode and coprocessor register fields ignored here
// - Coprocessor number field carried to coprocessor
// - Move into program counter loads only flags
// - Move from program counter sends flags too
// - Offset shifted two places, direction from up bit
// - Pre-index bit orders offset; writeback bit stores
module coproc_transfer_port
   import coproc_pkg::*;
(
   input  wire logic        clk,                 // 125 MHz clock
   input  wire logic        reset,               // Synchronous reset
   input  wire logic        instr_valid,         // Instruction offered
   input  wire logic [31:0] instr,               // Instruction word
   input  wire logic [31:0] instr_addr,          // Address of instruction
   input  wire logic [31:0] base_value,          // Base register value
   input  wire logic [31:0] rd_value,            // Source register value
   input  wire logic [1:0]  irq_masks,           // Interrupt disable bits
   input  wire logic [1:0]  mode,                // Processor mode, 0 user
   input  wire logic        cp_last,             // Pin: coprocessor last word
   input  wire logic        mem_abort,           // Pin: memory manager abort
   input  wire logic [31:0] cp_data_in,          // Pin: coprocessor word
   output logic             busy,                // Instruction in progress
   output logic             done,                // Instruction finished
   output logic             mem_req,             // Transfer address valid
   output logic [25:0]      mem_addr,            // Transfer address
   output logic             user_translate_low,  // Force user translation
   output logic             coproc_store,        // Store direction
   output logic             xfer_long,           // Long transfer selected
   output logic [3:0]       coproc_number_field, // Coprocessor selected
   output logic             addr_exception,      // Address exception trap
   output logic             data_abort_trap,     // Data abort trap
   output logic             wb_en,               // Register writeback
   output logic [3:0]       wb_reg,              // Writeback register
   output logic [31:0]      wb_data,             // Writeback value
   output logic [3:0]       status_flags,        // N Z C V
   output logic [31:0]      cp_data_out,         // Word to coprocessor
   output logic             cp_data_out_valid    // Word offered
);

   // ==========================================
   // Pin synchronisers
   logic        last_meta, last_s, abort_meta, abort_s;
   logic [31:0] data_meta, data_s;

   always_ff @(posedge clk) begin
      if (reset) begin
         last_meta  <= 1'b0;
         last_s     <= 1'b0;
         abort_meta <= 1'b0;
         abort_s    <= 1'b0;
         data_meta  <= 32'h0000_0000;
         data_s     <= 32'h0000_0000;
      end else begin
         last_meta  <= cp_last;
         last_s     <= last_meta;
         abort_meta <= mem_abort;
         abort_s    <= abort_meta;
         data_meta  <= cp_data_in;
         data_s     <= data_meta;
      end
   end

   // ==========================================
   // Decode and address forming
   state_t      state;
   logic        cond_pass, is_mem, is_regx, legal, accept, pre, wb_bit, priv;
   logic [3:0]  rn, rd;
   logic [31:0] pc_base, base, word_off, eff, first;

   cond_check u_cond (
      .cond  (instr[COND_MSB:COND_LSB]),
      .flags (status_flags),
      .pass  (cond_pass)
   );

   always_comb begin
      // Opcode, auxiliary and coprocessor register fields stay unread
      is_mem   = instr[CLASS_MSB:MEM_LSB] == CLASS_MEM;
      is_regx  = (instr[CLASS_MSB:REGX_LSB] == CLASS_REGX) && instr[BIT_REGX];
      pre      = instr[BIT_PRE];
      wb_bit   = instr[BIT_WB];
      rn       = instr[RN_MSB:RN_LSB];
      rd       = instr[RD_MSB:RD_LSB];
      priv     = mode != 2'b00;
      pc_base  = (instr_addr + PC_AHEAD) & PC_ADDR_MSK;
      base     = (rn == REG_PC) ? pc_base : base_value;
      word_off = 32'({instr[OFF_MSB:0], 2'b00});
      eff      = instr[BIT_UP] ? base + word_off : base - word_off;
      first    = pre ? eff : base;
      legal    = first[31:ADDR_BITS] == '0;
      accept   = (state == ST_IDLE) && instr_valid && cond_pass
                 && ((is_mem && legal) || is_regx);
   end

   // ==========================================
   // Sequencer
   logic        mem_end, last_pending;
   logic        wb_pending, pre_saved;
   logic [31:0] wb_value;
   logic [3:0]  rn_saved, rd_saved;

   assign mem_end = (state == ST_MEM) && (abort_s || last_s);

   always_ff @(posedge clk) begin
      if (reset) begin
         state <= ST_IDLE;
         busy  <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: if (accept) begin
               busy <= 1'b1;
               if (is_mem)
                  state <= ST_MEM;
               else if (instr[BIT_LOAD])
                  state <= ST_MOVE_IN;
               else
                  state <= ST_MOVE_OUT;
            end
            ST_MEM: if (abort_s || last_s) begin
               state <= ST_IDLE;
               busy  <= 1'b0;
            end
            ST_MOVE_IN, ST_MOVE_OUT: if (last_s) begin
               state <= ST_IDLE;
               busy  <= 1'b0;
            end
            default: begin
               state <= ST_IDLE;
               busy  <= 1'b0;
            end
         endcase
      end
   end

   assign last_pending = ((state == ST_MOVE_IN) || (state == ST_MOVE_OUT)) && last_s;

   // Done covers skipped, trapped and completed instructions
   always_ff @(posedge clk) begin
      if (reset)
         done <= 1'b0;
      else
         done <= ((state == ST_IDLE) && instr_valid && !accept) || mem_end || last_pending;
   end

   // ==========================================
   // Captured instruction state
   always_ff @(posedge clk) begin
      if (reset) begin
         coproc_store        <= 1'b0;
         xfer_long           <= 1'b0;
         coproc_number_field <= 4'h0;
         wb_pending          <= 1'b0;
         pre_saved           <= 1'b0;
         wb_value            <= 32'h0000_0000;
         rn_saved            <= 4'h0;
         rd_saved            <= 4'h0;
      end else if (accept) begin
         coproc_store        <= !instr[BIT_LOAD];
         xfer_long           <= instr[BIT_LONG];
         coproc_number_field <= instr[CPN_MSB:CPN_LSB];
         wb_pending          <= !pre || wb_bit;
         pre_saved           <= pre;
         wb_value            <= eff;
         rn_saved            <= rn;
         rd_saved            <= rd;
      end
   end

   // ==========================================
   // Memory transfer addressing
   always_ff @(posedge clk) begin
      if (reset) begin
         mem_req            <= 1'b0;
         mem_addr           <= 26'h000_0000;
         user_translate_low <= 1'b1;
      end else if (accept && is_mem) begin
         mem_req            <= 1'b1;
         mem_addr           <= first[ADDR_BITS-1:0];
         user_translate_low <= !(priv && !pre && wb_bit);
      end else if (mem_end) begin
         mem_req            <= 1'b0;
         user_translate_low <= 1'b1;
      end else if (state == ST_MEM) begin
         mem_addr <= mem_addr + WORD_STEP;
      end
   end

   // ==========================================
   // Traps
   always_ff @(posedge clk) begin
      if (reset) begin
         addr_exception  <= 1'b0;
         data_abort_trap <= 1'b0;
      end else begin
         addr_exception  <= (state == ST_IDLE) && instr_valid && cond_pass
                            && is_mem && !legal;
         data_abort_trap <= (state == ST_MEM) && abort_s;
      end
   end

   // ==========================================
   // Writeback and flags
   always_ff @(posedge clk) begin
      if (reset) begin
         wb_en   <= 1'b0;
         wb_reg  <= 4'h0;
         wb_data <= 32'h0000_0000;
      end else if (mem_end) begin
         wb_en   <= wb_pending;
         wb_reg  <= rn_saved;
         wb_data <= wb_value;
      end else if ((state == ST_MOVE_IN) && last_s) begin
         wb_en   <= rd_saved != REG_PC;
         wb_reg  <= rd_saved;
         wb_data <= data_s;
      end else begin
         wb_en <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset)
         status_flags <= 4'h0;
      else if ((state == ST_MOVE_IN) && last_s && (rd_saved == REG_PC))
         status_flags <= data_s[FLAG_MSB:FLAG_LSB];
   end

   // ==========================================
   // Word to coprocessor
   always_ff @(posedge clk) begin
      if (reset) begin
         cp_data_out       <= 32'h0000_0000;
         cp_data_out_valid <= 1'b0;
      end else if (accept && is_regx && !instr[BIT_LOAD]) begin
         cp_data_out_valid <= 1'b1;
         if (rd == REG_PC)
            cp_data_out <= {status_flags, irq_masks, pc_base[ADDR_BITS-1:OFF_SHIFT], mode};
         else
            cp_data_out <= rd_value;
      end else if ((state == ST_MOVE_OUT) && last_s) begin
         cp_data_out_valid <= 1'b0;
      end
   end

   // ==========================================
   // Checks
   chk_addr_step: assert property (@(posedge clk) disable iff (reset)
      (state == ST_MEM && !abort_s && !last_s) |=> mem_addr == $past(mem_addr) + WORD_STEP)
      else $error("address did not advance by one word");

   chk_pc_align: assert property (@(posedge clk) disable iff (reset)
      (accept && is_mem && rn == REG_PC) |=> mem_addr[1:0] == 2'b00)
      else $error("program counter base kept flag bits");

   chk_pc_ahead: assert property (@(posedge clk) disable iff (reset)
      (accept && is_mem && rn == REG_PC && !pre)
      |=> mem_addr[ADDR_BITS-1:OFF_SHIFT]
          == $past(instr_addr[ADDR_BITS-1:OFF_SHIFT]) + 24'(PC_AHEAD >> OFF_SHIFT))
      else $error("program counter base not eight ahead");

   chk_user_translate_low_pin: assert property (@(posedge clk) disable iff (reset)
      (accept && is_mem) |=> user_translate_low == !($past(priv) && !$past(pre) && $past(wb_bit)))
      else $error("translation pin wrong for transfer");

   chk_addr_trap: assert property (@(posedge clk) disable iff (reset)
      ((state == ST_IDLE) && instr_valid && cond_pass && is_mem && !legal)
      |=> addr_exception && !mem_req ##1 !addr_exception)
      else $error("illegal first address not trapped");

   chk_abort_wb: assert property (@(posedge clk) disable iff (reset)
      (state == ST_MEM && abort_s) |=> data_abort_trap && wb_en == $past(wb_pending) && !mem_req)
      else $error("abort lost trap or writeback");

   chk_post_wb: assert property (@(posedge clk) disable iff (reset)
      (mem_end && !pre_saved) |=> wb_en && wb_reg == $past(rn_saved))
      else $error("post-indexed transfer skipped writeback");

   chk_pre_nowb: assert property (@(posedge clk) disable iff (reset)
      (accept && is_mem && pre && !wb_bit) |=> !wb_pending && pre_saved)
      else $error("pre-indexed writeback without request");

   chk_skip_cond: assert property (@(posedge clk) disable iff (reset)
      ((state == ST_IDLE) && instr_valid && !cond_pass) |=> done && !busy && !mem_req)
      else $error("failed condition not skipped");

   chk_flag_load: assert property (@(posedge clk) disable iff (reset)
      ((state == ST_MOVE_IN) && last_s && rd_saved == REG_PC)
      |=> status_flags == $past(data_s[FLAG_MSB:FLAG_LSB]) && !wb_en)
      else $error("flags not loaded from word top bits");

   chk_long_sel: assert property (@(posedge clk) disable iff (reset)
      accept |=> xfer_long == $past(instr[BIT_LONG]))
      else $error("length selector not carried");

   chk_end_wb: assert property (@(posedge clk) disable iff (reset)
      mem_end |=> wb_en == $past(wb_pending) && wb_reg == $past(rn_saved)
                  && wb_data == $past(wb_value))
      else $error("base writeback wrong at transfer end");

   chk_out_flags: assert property (@(posedge clk) disable iff (reset)
      (accept && is_regx && !instr[BIT_LOAD] && rd == REG_PC)
      |=> cp_data_out_valid && cp_data_out[FLAG_MSB:FLAG_LSB] == $past(status_flags))
      else $error("program counter word sent without flags");

   chk_flags_hold: assert property (@(posedge clk) disable iff (reset)
      !((state == ST_MOVE_IN) && last_s && (rd_saved == REG_PC)) |=> $stable(status_flags))
      else $error("flags changed outside a move into program counter");

   chk_move_rd: assert property (@(posedge clk) disable iff (reset)
      ((state == ST_MOVE_IN) && last_s && rd_saved != REG_PC)
      |=> wb_en && wb_reg == $past(rd_saved) && wb_data == $past(data_s))
      else $error("moved word not written to register");

   chk_mem_hold: assert property (@(posedge clk) disable iff (reset)
      ((state == ST_MEM) && !mem_end) |=> mem_req && busy)
      else $error("transfer stopped before last word");

   chk_cpn_carry: assert property (@(posedge clk) disable iff (reset)
      accept |=> coproc_number_field == $past(instr[CPN_MSB:CPN_LSB]))
      else $error("coprocessor number not carried");

   chk_trap_nowb: assert property (@(posedge clk) disable iff (reset)
      addr_exception |-> !wb_en && !busy && !mem_req)
      else $error("trapped transfer still acted");

endmodule

// File: coproc_partner.sv
// Coprocessor and memory manager model facing the transfer port.
// Assumes the bench sets lat, abort_req and word before each instruction.
module coproc_partner #(
   parameter logic [3:0] OWN_NUM = 4'h1
) (
   input  wire logic        clk,                 // Processor clock
   input  wire logic        reset,               // Synchronous reset
   input  wire logic        busy,                // Port busy
   input  wire logic [3:0]  coproc_number_field, // Selected coprocessor
   input  wire logic [3:0]  lat,                 // Cycles before answer
   input  wire logic        abort_req,           // Answer with abort
   input  wire logic [31:0] word,                // Word to return
   output logic             cp_last,             // Last word pin
   output logic             mem_abort,           // Abort pin
   output logic [31:0]      cp_data_in           // Data pins
);
   logic [3:0] count;

   // ==========================================
   // Answer after lat cycles, hold until busy drops
   always_ff @(posedge clk) begin
      if (reset) begin
         count      <= 4'h0;
         cp_last    <= 1'b0;
         mem_abort  <= 1'b0;
         cp_data_in <= 32'h0000_0000;
      end else if (!busy) begin
         count      <= 4'h0;
         cp_last    <= 1'b0;
         mem_abort  <= 1'b0;
         cp_data_in <= ~cp_data_in; // Released pins never hold a value
      end else if (coproc_number_field == OWN_NUM) begin
         if (count == lat) begin
            cp_last    <= !abort_req;
            mem_abort  <= abort_req;
            cp_data_in <= word;
         end else begin
            count <= count + 4'h1;
         end
      end
   end
endmodule

// File: testbench.sv
// Self-checking bench for the coprocessor transfer port.
// Assumes the partner model answers every instruction for number 1.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import coproc_pkg::*;

   logic clk, reset, instr_valid, cp_last, mem_abort, abort_req;
   logic [31:0] instr, instr_addr, base_value, rd_value, cp_data_in, word;
   logic [1:0] irq_masks, mode;
   logic [3:0] lat;
   logic busy, done, mem_req, user_translate_low, coproc_store, xfer_long;
   logic addr_exception, data_abort_trap, wb_en, cp_data_out_valid;
   logic [25:0] mem_addr, first_addr, prev;
   logic [3:0] coproc_number_field, wb_reg, status_flags, s_cpn, s_wb_reg;
   logic [31:0] wb_data, cp_data_out, s_wb_data, got_out;
   logic tr_seen, s_long, s_wb_en, s_ae, s_da, got_done;
   int nwords, err_total, comparisons;

   coproc_transfer_port i_dut (.clk(clk), .reset(reset), .instr_valid(instr_valid),
      .instr(instr), .instr_addr(instr_addr), .base_value(base_value), .rd_value(rd_value),
      .irq_masks(irq_masks), .mode(mode), .cp_last(cp_last), .mem_abort(mem_abort),
      .cp_data_in(cp_data_in), .busy(busy), .done(done), .mem_req(mem_req),
      .mem_addr(mem_addr), .user_translate_low(user_translate_low),
      .coproc_store(coproc_store), .xfer_long(xfer_long),
      .coproc_number_field(coproc_number_field), .addr_exception(addr_exception),
      .data_abort_trap(data_abort_trap), .wb_en(wb_en), .wb_reg(wb_reg),
      .wb_data(wb_data), .status_flags(status_flags), .cp_data_out(cp_data_out),
      .cp_data_out_valid(cp_data_out_valid));
   coproc_partner i_partner (.clk(clk), .reset(reset), .busy(busy),
      .coproc_number_field(coproc_number_field), .lat(lat), .abort_req(abort_req),
      .word(word), .cp_last(cp_last), .mem_abort(mem_abort), .cp_data_in(cp_data_in));

   // ==========================================
   // Clock, compares and closing report
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      check_val({31'h0, got}, {31'h0, exp});
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // ==========================================
   // Instruction builders and one transfer
   function automatic logic [31:0] mem_ins(input logic p, u, n, w, l, input logic [3:0] rn,
                                           input logic [7:0] off);
      return {4'he, 3'b110, p, u, n, w, l, rn, 4'h7, 4'h1, off};
   endfunction

   function automatic logic [31:0] reg_ins(input logic [3:0] c, input logic l,
                                           input logic [3:0] rd);
      return {c, 4'he, 3'h5, l, 4'ha, rd, 4'h1, 3'h6, 1'b1, 4'hc};
   endfunction

   task automatic issue(input logic [31:0] ins, base, iaddr, input logic [3:0] lt,
                        input logic ab, input logic [31:0] wd);
      repeat (4) @(posedge clk);
      instr <= ins;
      base_value <= base;
      instr_addr <= iaddr;
      lat <= lt;
      abort_req <= ab;
      word <= wd;
      instr_valid <= 1'b1;
      @(posedge clk);
      instr_valid <= 1'b0;
      nwords = 0;
      got_done = 1'b0;
      for (int i = 0; i < 60 && !got_done; i++) begin
         #1;
         if (mem_req === 1'b1) begin
            if (nwords == 0) begin
               first_addr = mem_addr;
               tr_seen = user_translate_low;
               s_long = xfer_long;
               s_cpn = coproc_number_field;
            end else check_val({6'h0, mem_addr}, {6'h0, prev + WORD_STEP});
            prev = mem_addr;
            nwords++;
         end
         if (cp_data_out_valid === 1'b1) got_out = cp_data_out;
         if (done === 1'b1) begin
            got_done = 1'b1;
            {s_wb_en, s_wb_reg, s_wb_data, s_ae, s_da} =
               {wb_en, wb_reg, wb_data, addr_exception, data_abort_trap};
         end else @(posedge clk);
      end
      if (!got_done) begin
         err_total++;
         tally_and_finish();
      end
   endtask

   // ==========================================
   // Scenarios
   task automatic t_post_priv();
      mode <= 2'h3;
      issue(mem_ins(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 4'h2, 8'h03), 32'h0000_1000, 32'h0, 4'h3,
            1'b0, 32'h0);
      check_val({6'h0, first_addr}, 32'h0000_1000);
      check_bit(tr_seen, 1'b0);
      check_bit(s_long, 1'b1);
      check_val({28'h0, s_cpn}, 32'h0000_0001);
      check_bit(nwords >= 4, 1'b1);
      check_val({27'h0, s_wb_en, s_wb_reg}, 32'h0000_0012);
      check_val(s_wb_data, 32'h0000_100c);
      check_bit(coproc_store, 1'b1);
      $display("post-indexed privileged store done");
   endtask

   task automatic t_pc_pre();
      mode <= 2'h0;
      issue(mem_ins(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 4'hf, 8'hff), 32'hdead_beef,
            32'ha400_0800, 4'h0, 1'b0, 32'h0);
      check_val({6'h0, first_addr}, 32'h0000_040c);
      check_bit(s_wb_en, 1'b0);
      check_bit(tr_seen, 1'b1);
      check_bit(s_long, 1'b0);
      check_bit(coproc_store, 1'b0);
      issue(mem_ins(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 4'hf, 8'h00), 32'hdead_beef,
            32'hfc00_0200, 4'h0, 1'b0, 32'h0);
      check_val({6'h0, first_addr}, 32'h0000_0208);
      check_val({27'h0, s_wb_en, s_wb_reg}, 32'h0000_001f);
      $display("program counter pre-indexed load done");
   endtask

   task automatic t_addr_range();
      issue(mem_ins(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 4'h4, 8'h01), 32'h0400_0000, 32'h0, 4'h0,
            1'b0, 32'h0);
      check_val({30'h0, s_ae, s_wb_en}, 32'h0000_0002);
      check_val(nwords, 0);
      issue(mem_ins(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h4, 8'h04), 32'h0400_0000, 32'h0, 4'h0,
            1'b0, 32'h0);
      check_val({6'h0, first_addr}, 32'h03ff_fff0);
      check_bit(s_ae, 1'b0);
      issue(mem_ins(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 4'h4, 8'h04), 32'h03ff_fff8, 32'h0, 4'h2,
            1'b0, 32'h0);
      check_bit(s_ae, 1'b0);
      check_bit(tr_seen, 1'b1);
      check_val(s_wb_data, 32'h0400_0008);
      $display("address range and wrap done");
   endtask

   task automatic t_abort();
      issue(mem_ins(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 4'h5, 8'h02), 32'h0000_2000, 32'h0, 4'h1,
            1'b1, 32'h0);
      check_val({29'h0, s_da, s_ae, s_wb_en}, 32'h0000_0005);
      check_val(s_wb_data, 32'h0000_2008);
      $display("data abort done");
   endtask

   task automatic t_moves();
      issue(reg_ins(4'he, 1'b1, 4'hf), 32'h0, 32'h0, 4'h2, 1'b0, 32'h5abc_def0);
      check_val({28'h0, status_flags}, 32'h0000_0005);
      check_bit(s_wb_en, 1'b0);
      issue(reg_ins(4'h1, 1'b1, 4'h3), 32'h0, 32'h0, 4'h0, 1'b0, 32'h1234_5678);
      check_bit(s_wb_en, 1'b0);
      issue(reg_ins(4'h0, 1'b1, 4'h3), 32'h0, 32'h0, 4'h1, 1'b0, 32'h1234_5678);
      check_val({27'h0, s_wb_en, s_wb_reg}, 32'h0000_0013);
      check_val(s_wb_data, 32'h1234_5678);
      irq_masks <= 2'h2;
      mode <= 2'h1;
      issue(reg_ins(4'he, 1'b0, 4'hf), 32'h0, 32'h0000_0400, 4'h2, 1'b0, 32'h0);
      check_val(got_out, {4'h5, 2'h2, 24'h00_0102, 2'h1});
      rd_value <= 32'hc0de_0123;
      issue(reg_ins(4'he, 1'b0, 4'h3), 32'h0, 32'h0, 4'h1, 1'b0, 32'h0);
      check_val(got_out, 32'hc0de_0123);
      check_bit(cp_data_out_valid, 1'b0);
      $display("register transfers done");
   endtask

   // ==========================================
   // Main sequence
   initial begin
      {err_total, comparisons} = '0;
      {reset, instr_valid, instr, instr_addr, base_value} = {1'b1, 1'b0, 96'h0};
      {rd_value, irq_masks, mode, lat, abort_req, word} = '0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      #1;
      check_val({28'h0, status_flags}, 32'h0);
      check_bit(user_translate_low, 1'b1);
      check_bit(busy, 1'b0);
      t_post_priv();
      t_pc_pre();
      t_addr_range();
      t_abort();
      t_moves();
      tally_and_finish();
   end
endmodule
